// file: inc/cfg_group_pkg.sv
// Purpose : Constants and types for the indexed configuration group 07h..0Eh
// Assumes : Byte-wide configuration data, one clock domain
// Notes   : Register offsets are the configuration index values

package cfg_group_pkg;

   // ****************************************
   // Register indexes
   // ****************************************
   localparam logic [7:0] POWER_BOOT_CTRL_IDX    = 8'h07;
   localparam logic [7:0] AUX_BASE_LOW_IDX       = 8'h08;
   localparam logic [7:0] AUX_BASE_HIGH_CFG_IDX  = 8'h09;
   localparam logic [7:0] IR_ROUTE_THRESHOLD_IDX = 8'h0A;
   localparam logic [7:0] DRIVE_RATE_SEL_IDX     = 8'h0B;
   localparam logic [7:0] SERIAL_MODE_CTRL_IDX   = 8'h0C;
   localparam logic [7:0] DEVICE_IDENT_IDX       = 8'h0D;
   localparam logic [7:0] SILICON_REV_IDX        = 8'h0E;

   // ****************************************
   // Reset values and writable masks
   // ****************************************
   localparam logic [7:0] POWER_BOOT_RESET     = 8'h00;
   localparam logic [7:0] AUX_LOW_RESET        = 8'h00;
   localparam logic [7:0] AUX_HIGH_RESET       = 8'h00;
   localparam logic [7:0] IR_THRESHOLD_RESET   = 8'h00;
   localparam logic [7:0] RATE_SEL_RESET       = 8'h00;
   localparam logic [7:0] SERIAL_MODE_RESET    = 8'h02;
   localparam logic [7:0] POWER_BOOT_MASK      = 8'hF3;
   localparam logic [7:0] AUX_LOW_MASK         = 8'hF0;
   localparam logic [7:0] AUX_HIGH_MASK        = 8'hC7;
   localparam logic [7:0] IR_THRESHOLD_MASK    = 8'hCF;
   localparam logic [7:0] RATE_SEL_MASK        = 8'hFF;
   localparam logic [7:0] SERIAL_MODE_MASK     = 8'hFF;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BOOT_DRIVE_BIT    = 0;
   localparam int PD_PARALLEL_BIT   = 4;
   localparam int PD_SERIAL2_BIT    = 5;
   localparam int PD_SERIAL1_BIT    = 6;
   localparam int PD_FLOPPY_BIT     = 7;
   localparam int AUX_SIZE_LSB      = 6;
   localparam int IR_ROUTE_LSB      = 6;
   localparam int RX_POL_BIT        = 0;
   localparam int TX_POL_BIT        = 1;
   localparam int HALF_DUPLEX_BIT   = 2;
   localparam int LINE_MODE_LSB     = 3;
   localparam int SERIAL1_FAST_BIT  = 6;
   localparam int SERIAL2_FAST_BIT  = 7;

   // ****************************************
   // Encodings
   // ****************************************
   localparam logic [1:0] AUX_SIZE_OFF   = 2'h0;
   localparam logic [1:0] AUX_SIZE_ONE   = 2'h1;
   localparam logic [1:0] AUX_SIZE_EIGHT = 2'h2;
   localparam logic [1:0] IR_TO_PRIMARY  = 2'h0;
   localparam logic [1:0] IR_TO_ALTERNATE = 2'h1;
   localparam logic [1:0] PIN_FUNC_IR_ALT = 2'h3;

   typedef struct packed {
      logic       mode;
      logic [7:0] index;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } cfg_req_type;

   typedef struct packed {
      logic       rx_active_low;
      logic       tx_active_low;
      logic       half_duplex;
      logic [2:0] line_mode;
      logic       serial1_fast;
      logic       serial2_fast;
   } serial_mode_type;

   typedef struct packed {
      logic parallel;
      logic serial2;
      logic serial1;
      logic floppy;
   } powerdown_type;

endpackage : cfg_group_pkg

// file: design/cfg_group_regs.sv
// Purpose : Configuration registers 07h..0Eh with auxiliary decoder and infrared pin mux
// Assumes : Configuration index register and mode flag live outside this block
// Notes   : RESET_IN covers both power-on and hardware reset
`timescale 1ns/1ps

module cfg_group_regs #(
   parameter logic [7:0] DEVICE_IDENT = 8'hA5,  // Arbitrary value
   parameter logic [7:0] SILICON_REV  = 8'h5A   // Arbitrary value
) (
   input  wire logic                          CLK_SYS_IN,
   input  wire logic                          RESET_IN,
   input  wire cfg_group_pkg::cfg_req_type    CFG_REQ_IN,
   output logic [7:0]                         CFG_RDATA_OUT,
   output logic                               CFG_RHIT_OUT,
   output logic                               BOOT_DRIVE_B_OUT,
   output cfg_group_pkg::powerdown_type       AUTO_POWERDOWN_OUT,
   output logic [3:0]                         EXT_CAP_FIFO_THRESHOLD_OUT,
   output logic [7:0]                         DRIVE_RATE_SEL_OUT,
   output cfg_group_pkg::serial_mode_type     SERIAL_MODE_OUT,
   input  wire logic [10:0]                   HOST_ADDR_IN,
   input  wire logic                          HOST_SELECT_N_IN,
   output logic                               AUX_DECODE_OUT,
   input  wire logic [1:0]                    PIN_FUNCTION_CFG_IN,
   input  wire logic                          SERIAL2_TX_IN,
   input  wire logic                          IR_RECEIVE_PRIMARY_IN,
   input  wire logic                          IR_RECEIVE_ALTERNATE_IN,
   output logic                               SERIAL2_RX_OUT,
   output logic                               IR_TRANSMIT_PRIMARY_OUT,
   output logic                               IR_TRANSMIT_PRIMARY_OE_N_OUT,
   output logic                               IR_TRANSMIT_ALTERNATE_OUT,
   output logic                               IR_TRANSMIT_ALTERNATE_OE_N_OUT
);

   // ****************************************
   // Access decode
   // ****************************************
   function automatic logic idx_hit(input cfg_group_pkg::cfg_req_type req,
                                    input logic [7:0]                 idx);
      idx_hit = req.mode && (req.index == idx);
   endfunction : idx_hit

   function automatic logic [7:0] masked_write(input logic [7:0] wdata,
                                               input logic [7:0] mask);
      masked_write = wdata & mask;
   endfunction : masked_write

   logic [7:0] power_boot_r;
   logic [7:0] aux_low_r;
   logic [7:0] aux_high_r;
   logic [7:0] ir_threshold_r;
   logic [7:0] rate_sel_r;
   logic [7:0] serial_mode_r;
   logic       wr_en;
   logic [7:0] rdata_nxt;
   logic       rhit_nxt;

   assign wr_en = CFG_REQ_IN.wr;

   // ****************************************
   // Register storage
   // ****************************************
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         power_boot_r <= cfg_group_pkg::POWER_BOOT_RESET;
      end else if (wr_en && idx_hit(CFG_REQ_IN, cfg_group_pkg::POWER_BOOT_CTRL_IDX)) begin
         power_boot_r <= masked_write(CFG_REQ_IN.wdata, cfg_group_pkg::POWER_BOOT_MASK);
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         aux_low_r  <= cfg_group_pkg::AUX_LOW_RESET;
         aux_high_r <= cfg_group_pkg::AUX_HIGH_RESET;
      end else if (wr_en) begin
         if (idx_hit(CFG_REQ_IN, cfg_group_pkg::AUX_BASE_LOW_IDX)) begin
            aux_low_r <= masked_write(CFG_REQ_IN.wdata, cfg_group_pkg::AUX_LOW_MASK);
         end
         if (idx_hit(CFG_REQ_IN, cfg_group_pkg::AUX_BASE_HIGH_CFG_IDX)) begin
            aux_high_r <= masked_write(CFG_REQ_IN.wdata, cfg_group_pkg::AUX_HIGH_MASK);
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         ir_threshold_r <= cfg_group_pkg::IR_THRESHOLD_RESET;
      end else if (wr_en && idx_hit(CFG_REQ_IN, cfg_group_pkg::IR_ROUTE_THRESHOLD_IDX)) begin
         ir_threshold_r <= masked_write(CFG_REQ_IN.wdata, cfg_group_pkg::IR_THRESHOLD_MASK);
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         rate_sel_r <= cfg_group_pkg::RATE_SEL_RESET;
      end else if (wr_en && idx_hit(CFG_REQ_IN, cfg_group_pkg::DRIVE_RATE_SEL_IDX)) begin
         rate_sel_r <= masked_write(CFG_REQ_IN.wdata, cfg_group_pkg::RATE_SEL_MASK);
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         serial_mode_r <= cfg_group_pkg::SERIAL_MODE_RESET;
      end else if (wr_en && idx_hit(CFG_REQ_IN, cfg_group_pkg::SERIAL_MODE_CTRL_IDX)) begin
         serial_mode_r <= masked_write(CFG_REQ_IN.wdata, cfg_group_pkg::SERIAL_MODE_MASK);
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Identifier registers have no storage, so writes to them simply land nowhere
   always_comb begin
      rdata_nxt = 8'h00;
      rhit_nxt  = 1'b0;
      if (CFG_REQ_IN.rd && CFG_REQ_IN.mode) begin
         rhit_nxt = 1'b1;
         case (CFG_REQ_IN.index)
            cfg_group_pkg::POWER_BOOT_CTRL_IDX:    rdata_nxt = power_boot_r;
            cfg_group_pkg::AUX_BASE_LOW_IDX:       rdata_nxt = aux_low_r;
            cfg_group_pkg::AUX_BASE_HIGH_CFG_IDX:  rdata_nxt = aux_high_r;
            cfg_group_pkg::IR_ROUTE_THRESHOLD_IDX: rdata_nxt = ir_threshold_r;
            cfg_group_pkg::DRIVE_RATE_SEL_IDX:     rdata_nxt = rate_sel_r;
            cfg_group_pkg::SERIAL_MODE_CTRL_IDX:   rdata_nxt = serial_mode_r;
            cfg_group_pkg::DEVICE_IDENT_IDX:       rdata_nxt = DEVICE_IDENT;
            cfg_group_pkg::SILICON_REV_IDX:        rdata_nxt = SILICON_REV;
            default:                               rhit_nxt  = 1'b0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         CFG_RDATA_OUT <= 8'h00;
         CFG_RHIT_OUT  <= 1'b0;
      end else begin
         CFG_RDATA_OUT <= rdata_nxt;
         CFG_RHIT_OUT  <= rhit_nxt;
      end
   end

   // ****************************************
   // Field outputs
   // ****************************************
   // Mirrored one cycle behind the register so every output leaves a flop
   // One field split serves the reset image and the live copy, so the two cannot drift apart
   function automatic cfg_group_pkg::serial_mode_type serial_fields(input logic [7:0] r);
      serial_fields.rx_active_low = r[cfg_group_pkg::RX_POL_BIT];
      serial_fields.tx_active_low = r[cfg_group_pkg::TX_POL_BIT];
      serial_fields.half_duplex   = r[cfg_group_pkg::HALF_DUPLEX_BIT];
      serial_fields.line_mode     = r[cfg_group_pkg::LINE_MODE_LSB +: 3];
      serial_fields.serial1_fast  = r[cfg_group_pkg::SERIAL1_FAST_BIT];
      serial_fields.serial2_fast  = r[cfg_group_pkg::SERIAL2_FAST_BIT];
   endfunction : serial_fields

   // The raw register byte does not line up with the exported field order
   localparam cfg_group_pkg::serial_mode_type SERIAL_MODE_OUT_RESET =
      serial_fields(cfg_group_pkg::SERIAL_MODE_RESET);

   cfg_group_pkg::serial_mode_type serial_mode_nxt;

   assign serial_mode_nxt = serial_fields(serial_mode_r);

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         BOOT_DRIVE_B_OUT       <= 1'b0;
         AUTO_POWERDOWN_OUT     <= '0;
         EXT_CAP_FIFO_THRESHOLD_OUT <= 4'h0;
         SERIAL_MODE_OUT        <= SERIAL_MODE_OUT_RESET;
      end else begin
         BOOT_DRIVE_B_OUT            <= power_boot_r[cfg_group_pkg::BOOT_DRIVE_BIT];
         AUTO_POWERDOWN_OUT.parallel <= power_boot_r[cfg_group_pkg::PD_PARALLEL_BIT];
         AUTO_POWERDOWN_OUT.serial2  <= power_boot_r[cfg_group_pkg::PD_SERIAL2_BIT];
         AUTO_POWERDOWN_OUT.serial1  <= power_boot_r[cfg_group_pkg::PD_SERIAL1_BIT];
         AUTO_POWERDOWN_OUT.floppy   <= power_boot_r[cfg_group_pkg::PD_FLOPPY_BIT];
         EXT_CAP_FIFO_THRESHOLD_OUT  <= ir_threshold_r[3:0];
         SERIAL_MODE_OUT             <= serial_mode_nxt;
      end
   end

   genvar drv;
   generate
      for (drv = 0; drv < 4; drv++) begin : g_rate
         always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
            if (RESET_IN) begin
               DRIVE_RATE_SEL_OUT[2*drv +: 2] <= 2'h0;
            end else begin
               DRIVE_RATE_SEL_OUT[2*drv +: 2] <= rate_sel_r[2*drv +: 2];
            end
         end
      end
   endgenerate

   // ****************************************
   // Auxiliary address decoder
   // ****************************************
   logic [10:0] aux_base;
   logic [1:0]  aux_size;
   logic        aux_upper_match;
   logic        aux_match;

   assign aux_base        = {aux_high_r[2:0], aux_low_r[7:4], 4'h0};
   assign aux_size        = aux_high_r[cfg_group_pkg::AUX_SIZE_LSB +: 2];
   assign aux_upper_match = HOST_ADDR_IN[10:4] == aux_base[10:4];

   always_comb begin
      case (aux_size)
         cfg_group_pkg::AUX_SIZE_OFF:   aux_match = 1'b0;
         cfg_group_pkg::AUX_SIZE_ONE:   aux_match = aux_upper_match && HOST_ADDR_IN[3:0] == 4'h0;
         cfg_group_pkg::AUX_SIZE_EIGHT: aux_match = aux_upper_match && !HOST_ADDR_IN[3];
         default:                       aux_match = aux_upper_match;
      endcase
   end

   // Registered for a clean output; costs one cycle after the address settles
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         AUX_DECODE_OUT <= 1'b0;
      end else begin
         AUX_DECODE_OUT <= aux_match && !HOST_SELECT_N_IN;
      end
   end

   // ****************************************
   // Infrared pin routing
   // ****************************************
   logic [1:0] ir_route;
   logic       rx_nxt;
   logic       tx_pri_nxt;
   logic       tx_pri_oe_n_nxt;
   logic       tx_alt_nxt;
   logic       tx_alt_oe_n_nxt;

   assign ir_route = ir_threshold_r[cfg_group_pkg::IR_ROUTE_LSB +: 2];

   // Reserved route code floats both outputs, the safest reading for an unknown board
   always_comb begin
      rx_nxt          = 1'b0;
      tx_pri_nxt      = 1'b0;
      tx_pri_oe_n_nxt = 1'b1;
      tx_alt_nxt      = 1'b0;
      tx_alt_oe_n_nxt = 1'b1;
      case (ir_route)
         cfg_group_pkg::IR_TO_PRIMARY: begin
            rx_nxt          = IR_RECEIVE_PRIMARY_IN;
            tx_pri_nxt      = SERIAL2_TX_IN;
            tx_pri_oe_n_nxt = 1'b0;
         end
         cfg_group_pkg::IR_TO_ALTERNATE: begin
            if (PIN_FUNCTION_CFG_IN == cfg_group_pkg::PIN_FUNC_IR_ALT) begin
               rx_nxt          = IR_RECEIVE_ALTERNATE_IN;
               tx_alt_nxt      = SERIAL2_TX_IN;
               tx_alt_oe_n_nxt = 1'b0;
            end
         end
         default: begin
            rx_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         SERIAL2_RX_OUT                 <= 1'b0;
         IR_TRANSMIT_PRIMARY_OUT        <= 1'b0;
         IR_TRANSMIT_PRIMARY_OE_N_OUT   <= 1'b1;
         IR_TRANSMIT_ALTERNATE_OUT      <= 1'b0;
         IR_TRANSMIT_ALTERNATE_OE_N_OUT <= 1'b1;
      end else begin
         SERIAL2_RX_OUT                 <= rx_nxt;
         IR_TRANSMIT_PRIMARY_OUT        <= tx_pri_nxt;
         IR_TRANSMIT_PRIMARY_OE_N_OUT   <= tx_pri_oe_n_nxt;
         IR_TRANSMIT_ALTERNATE_OUT      <= tx_alt_nxt;
         IR_TRANSMIT_ALTERNATE_OE_N_OUT <= tx_alt_oe_n_nxt;
      end
   end

endmodule : cfg_group_regs

// file: tb/cfg_group_regs_checker.sv
// Purpose : Assertions on the ports of the configuration group
// Assumes : One clock domain, reset asynchronous and active high
// Notes   : Field outputs follow a write by two edges
`timescale 1ns/1ps

module cfg_group_regs_checker #(
   parameter logic [7:0] DEVICE_IDENT = 8'hA5,  // Arbitrary value
   parameter logic [7:0] SILICON_REV  = 8'h5A   // Arbitrary value
) (
   input wire logic                           CLK_SYS_IN,
   input wire logic                           RESET_IN,
   input wire cfg_group_pkg::cfg_req_type     CFG_REQ_IN,
   input wire logic [7:0]                     CFG_RDATA_OUT,
   input wire logic                           CFG_RHIT_OUT,
   input wire logic                           BOOT_DRIVE_B_OUT,
   input wire cfg_group_pkg::powerdown_type   AUTO_POWERDOWN_OUT,
   input wire cfg_group_pkg::serial_mode_type SERIAL_MODE_OUT,
   input wire logic                           HOST_SELECT_N_IN,
   input wire logic                           AUX_DECODE_OUT,
   input wire logic                           IR_TRANSMIT_PRIMARY_OE_N_OUT,
   input wire logic                           IR_TRANSMIT_ALTERNATE_OE_N_OUT
);
   logic [7:0] wd_d1_r;
   logic [7:0] wd_d2_r;

   // Write data two edges back, lined up with the field output lag
   always_ff @(posedge CLK_SYS_IN) begin
      wd_d1_r <= CFG_REQ_IN.wdata;
      wd_d2_r <= wd_d1_r;
   end

   default clocking @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (RESET_IN);

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_wr(logic [7:0] idx);
      CFG_REQ_IN.mode && CFG_REQ_IN.wr && CFG_REQ_IN.index == idx;
   endsequence
   sequence s_rd(logic [7:0] idx);
      CFG_REQ_IN.mode && CFG_REQ_IN.rd && CFG_REQ_IN.index == idx;
   endsequence

   AST_READ_HIT: assert property (
      CFG_REQ_IN.mode && CFG_REQ_IN.rd && CFG_REQ_IN.index inside {[8'h07:8'h0E]}
      |=> CFG_RHIT_OUT) else $error("read in range gave no hit");
   AST_READ_REFUSED: assert property (
      CFG_REQ_IN.rd && !CFG_REQ_IN.mode |=> !CFG_RHIT_OUT && CFG_RDATA_OUT == 8'h00)
      else $error("read outside configuration mode answered");
   AST_IDENT: assert property (
      s_rd(8'h0D) |=> CFG_RDATA_OUT == DEVICE_IDENT) else $error("identifier read wrong");
   AST_REVISION: assert property (
      s_rd(8'h0E) |=> CFG_RDATA_OUT == SILICON_REV) else $error("revision read wrong");
   AST_RESERVED_ZERO: assert property (
      s_rd(8'h07) |=> CFG_RDATA_OUT[3:2] == 2'h0) else $error("reserved bits read nonzero");
   AST_AUX_NEEDS_SELECT: assert property (
      HOST_SELECT_N_IN |=> !AUX_DECODE_OUT) else $error("decode without host select");
   AST_POWER_BOOT: assert property (
      s_wr(8'h07) |-> ##2 BOOT_DRIVE_B_OUT == wd_d2_r[0] && AUTO_POWERDOWN_OUT ==
      {wd_d2_r[4], wd_d2_r[5], wd_d2_r[6], wd_d2_r[7]}) else $error("power/boot fields wrong");
   AST_SERIAL_MODE: assert property (
      s_wr(8'h0C) |-> ##2 SERIAL_MODE_OUT == {wd_d2_r[0], wd_d2_r[1], wd_d2_r[2],
      wd_d2_r[5:3], wd_d2_r[6], wd_d2_r[7]}) else $error("serial mode fields wrong");
   AST_IR_FLOAT: assert property (
      s_wr(8'h0A) ##0 CFG_REQ_IN.wdata[7:6] == 2'h3 |-> ##2
      IR_TRANSMIT_PRIMARY_OE_N_OUT && IR_TRANSMIT_ALTERNATE_OE_N_OUT)
      else $error("infrared outputs driven while floated");
endmodule : cfg_group_regs_checker

bind cfg_group_regs cfg_group_regs_checker #(
   .DEVICE_IDENT(DEVICE_IDENT), .SILICON_REV(SILICON_REV)
) checker_inst (
   .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .CFG_REQ_IN(CFG_REQ_IN),
   .CFG_RDATA_OUT(CFG_RDATA_OUT), .CFG_RHIT_OUT(CFG_RHIT_OUT),
   .BOOT_DRIVE_B_OUT(BOOT_DRIVE_B_OUT), .AUTO_POWERDOWN_OUT(AUTO_POWERDOWN_OUT),
   .SERIAL_MODE_OUT(SERIAL_MODE_OUT), .HOST_SELECT_N_IN(HOST_SELECT_N_IN),
   .AUX_DECODE_OUT(AUX_DECODE_OUT),
   .IR_TRANSMIT_PRIMARY_OE_N_OUT(IR_TRANSMIT_PRIMARY_OE_N_OUT),
   .IR_TRANSMIT_ALTERNATE_OE_N_OUT(IR_TRANSMIT_ALTERNATE_OE_N_OUT)
);

// file: tb/config_regs_power_ir_uart_mode_bench.sv
// Purpose : Self-checking bench for the configuration group
// Assumes : Inputs driven by non-blocking assignment at the rising edge
// Notes   : Identity values are arbitrary, chosen to differ from the defaults
`timescale 1ns/1ps

module config_regs_power_ir_uart_mode_bench;
   localparam logic [7:0] IDENT = 8'hC3;  // Arbitrary value
   localparam logic [7:0] REV   = 8'h3C;  // Arbitrary value
   logic                           clk = 1'b0;
   logic                           rst = 1'b1;
   cfg_group_pkg::cfg_req_type     req = '0;
   logic [10:0]                    addr = 11'h000;
   logic                           sel_n = 1'b1;
   logic [1:0]                     pin_fn = 2'h0;
   logic                           tx_in = 1'b0;
   logic                           rx_pri = 1'b0;
   logic                           rx_alt = 1'b0;
   logic [7:0]                     rdata;
   logic [7:0]                     rate;
   logic [3:0]                     thr;
   logic                           rhit, boot_b, aux, s2_rx, ptx, ptx_oen, atx, atx_oen;
   cfg_group_pkg::powerdown_type   pd;
   cfg_group_pkg::serial_mode_type smode;
   int                             fail_count = 0;
   int                             n_checks = 0;
   int                             cycles = 0;

   cfg_group_regs #(.DEVICE_IDENT(IDENT), .SILICON_REV(REV)) dut (
      .CLK_SYS_IN(clk), .RESET_IN(rst), .CFG_REQ_IN(req), .CFG_RDATA_OUT(rdata),
      .CFG_RHIT_OUT(rhit), .BOOT_DRIVE_B_OUT(boot_b), .AUTO_POWERDOWN_OUT(pd),
      .EXT_CAP_FIFO_THRESHOLD_OUT(thr), .DRIVE_RATE_SEL_OUT(rate), .SERIAL_MODE_OUT(smode),
      .HOST_ADDR_IN(addr), .HOST_SELECT_N_IN(sel_n), .AUX_DECODE_OUT(aux),
      .PIN_FUNCTION_CFG_IN(pin_fn), .SERIAL2_TX_IN(tx_in), .IR_RECEIVE_PRIMARY_IN(rx_pri),
      .IR_RECEIVE_ALTERNATE_IN(rx_alt), .SERIAL2_RX_OUT(s2_rx),
      .IR_TRANSMIT_PRIMARY_OUT(ptx), .IR_TRANSMIT_PRIMARY_OE_N_OUT(ptx_oen),
      .IR_TRANSMIT_ALTERNATE_OUT(atx), .IR_TRANSMIT_ALTERNATE_OE_N_OUT(atx_oen)
   );

   always #2.5 clk = ~clk;

   // Whole run needs well under 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d, input logic md = 1'b1);
      @(posedge clk);
      req <= '{mode: md, index: idx, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : cfg_wr

   task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp,
                         input logic md = 1'b1, input logic hit = 1'b1);
      @(posedge clk);
      req <= '{mode: md, index: idx, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      check(rdata, exp);
      check(8'(rhit), 8'(hit));
   endtask : cfg_rd

   // Field outputs trail the write edge by one more edge
   task automatic settle;
      @(posedge clk);
      #1;
   endtask : settle

   task automatic aux_probe(input logic [10:0] a, input logic sn, input logic exp);
      @(posedge clk);
      addr <= a;
      sel_n <= sn;
      @(posedge clk);
      #1;
      check(8'(aux), 8'(exp));
   endtask : aux_probe

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, IDENT, REV};
      logic [7:0]  rw_val [8] = '{8'hF3, 8'hF0, 8'hC7, 8'hCF, 8'hFF, 8'hFF, IDENT, REV};
      logic [10:0] probe [6] = '{11'h530, 11'h531, 11'h538, 11'h53F, 11'h540, 11'h130};
      logic        pri, alt;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) cfg_rd(8'(8'h07 + i), rst_val[i]);
      check({pd, 3'b000, boot_b}, 8'h00);
      check(8'(smode), 8'h40);
      check(8'({ptx_oen, atx_oen}), 8'h01);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         cfg_wr(8'(8'h07 + i), 8'hFF);
         cfg_rd(8'(8'h07 + i), rw_val[i]);
      end
      check({pd, 3'b000, boot_b}, 8'hF1);
      check(8'(smode), 8'hFF);
      check(8'({ptx_oen, atx_oen}), 8'h03);
      cfg_wr(8'h0B, 8'h00, 1'b0);
      cfg_rd(8'h0B, 8'h00, 1'b0, 1'b0);
      cfg_rd(8'h0B, 8'hFF);
      cfg_rd(8'h0F, 8'h00, 1'b1, 1'b0);
      cfg_rd(8'h06, 8'h00, 1'b1, 1'b0);
      $display("access and masks done");
      for (int m = 0; m < 8; m++) begin
         cfg_wr(8'h0C, 8'({m[2:0], 3'b000}));
         settle;
         check(8'(smode), 8'({m[2:0], 2'b00}));
      end
      cfg_wr(8'h0C, 8'hC5);
      settle;
      check(8'(smode), 8'hA3);
      cfg_wr(8'h0B, 8'hE4);
      settle;
      check(rate, 8'hE4);
      $display("serial and rate done");
      cfg_wr(8'h08, 8'h3F);
      for (int s = 0; s < 4; s++) begin
         cfg_wr(8'h09, {2'(s), 6'h05});
         for (int k = 0; k < 6; k++) begin
            aux_probe(probe[k], 1'b0, k < 4 && (s == 3 || (s == 2 && !probe[k][3])
                      || (s == 1 && probe[k][3:0] == 4'h0)));
         end
      end
      aux_probe(11'h530, 1'b1, 1'b0);
      $display("aux decoder done");
      for (int n = 0; n < 16; n++) begin
         @(posedge clk);
         pin_fn <= {n[1], n[1]};
         rx_pri <= n[0];
         rx_alt <= !n[0];
         tx_in <= n[0];
         cfg_wr(8'h0A, {n[3:2], 2'b00, 4'h9});
         settle;
         pri = n[3:2] == 2'h0;
         alt = n[3:2] == 2'h1 && n[1];
         check(8'(s2_rx), pri ? 8'(n[0]) : alt ? 8'(!n[0]) : 8'h00);
         check(8'({ptx_oen, atx_oen}), 8'({!pri, !alt}));
         if (pri) check(8'(ptx), 8'(n[0]));
         if (alt) check(8'(atx), 8'(n[0]));
      end
      check(8'(thr), 8'h09);
      $display("infrared mux done");
      cfg_wr(8'h07, 8'hF1);
      cfg_wr(8'h0A, 8'hC0);
      cfg_wr(8'h0C, 8'hFF);
      @(posedge clk);
      rst <= 1'b1;
      settle;
      check({pd, 3'b000, boot_b}, 8'h00);
      check(8'(smode), 8'h40);
      check(8'({ptx_oen, atx_oen}), 8'h03);
      @(posedge clk);
      rst <= 1'b0;
      cfg_rd(8'h07, 8'h00);
      cfg_rd(8'h0A, 8'h00);
      cfg_rd(8'h0C, 8'h02);
      check(8'({ptx_oen, atx_oen}), 8'h01);
      $display("mid-run reset done");
      summarize();
   end
endmodule : config_regs_power_ir_uart_mode_bench
